/* File: hw/qw_dev.sv */
// qw_dev: quad wiper command decoder, slave end of the two-wire link
// assumes: link pins asynchronous to CORE_CLK, host is sole clock source
//
// Functional notes
// - address high nibble type, low nibble pins
// - non-matching address: command ignored entirely
// - instruction: opcode, pot select, setting select
// - setting select picks setting zero to three
// - four 6-bit wipers, one-hot tap decode
// - wipers load setting zero after reset
// - four 6-bit stored settings per pot
// - stored-setting change programs within 5 ms
// - opcode 1001 reads wiper, msb first
// - opcode 1010 writes wiper from data byte
// - opcode 1011 reads selected stored setting
// - opcode 1100 writes selected stored setting
// - opcode 1101 copies setting into wiper
// - opcode 1110 copies wiper into setting
// - opcode 0001 copies settings into all wipers
// - opcode 1000 copies all wipers into settings
// - opcode 0010 enters stepping after acknowledge
// - step up on sda high, down low
// - busy programming: own address not acknowledged
// - read continues only on master acknowledge
// - acknowledge each written byte on ninth clock
//
// Added by the designer: the placing of the registers and the APB register port.
`default_nettype none

module qw_dev
  import qw_pkg::*;
#(
  parameter int NV_CYC = qw_pkg::NV_PROG_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  qw_if.dev LNK,
  input wire logic [3:0] ADDRESS_PINS,
  output qw_pkg::qw_wipers_t WIPER_POSITION,
  output qw_pkg::qw_taps_t TAP_SELECT,
  output logic NV_BUSY
);
  import qw_pkg::*;

  typedef enum {D_IDLE, D_ADDR, D_INSTR, D_WDATA, D_RDATA, D_STEP,
    D_SKIP} qw_dst_t;
  typedef enum {P_NONE, P_ONE_DATA, P_ONE_WIP, P_ALL_WIP} qw_pend_t;

  // ------------------------------------------------------------
  // pin inputs
  // ------------------------------------------------------------
  logic scl_lvl;
  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic sda_rise;
  logic sda_fall;
  logic start;
  logic stop;

  qw_pin_sync u_scl (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .pin(LNK.scl),
    .lvl(scl_lvl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  qw_pin_sync u_sda (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .pin(LNK.sda),
    .lvl(sda_lvl),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  assign start = sda_fall & scl_lvl;
  assign stop = sda_rise & scl_lvl;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  qw_dst_t st_q, st_d, nxt_q, nxt_d;
  qw_pend_t pend_q, pend_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] ins_q, ins_d;
  logic drv_q, drv_d;
  logic mack_q, mack_d;
  logic boot_q, boot_d;
  qw_val_t pdat_q, pdat_d;
  logic [BUSY_W-1:0] cnt_q, cnt_d;
  qw_val_t [3:0] wip_q, wip_d;
  qw_val_t [3:0][3:0] set_q, set_d;
  logic [7:0] rdv;
  logic [1:0] pot;
  logic [1:0] sel;
  logic [1:0] npot;
  logic [1:0] nsel;

  assign pot = ins_q[POT_LSB +: 2];
  assign sel = ins_q[SEL_LSB +: 2];
  assign npot = sh_q[POT_LSB +: 2];
  assign nsel = sh_q[SEL_LSB +: 2];

  // read value, upper bits zero
  always_comb
  begin
    if (ins_q[OP_LSB +: 4] == OP_RD_WIPER)
      rdv = {2'b00, wip_q[pot]};
    else
      rdv = {2'b00, set_q[pot][sel]};
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    nxt_d = nxt_q;
    pend_d = pend_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    ins_d = ins_q;
    drv_d = drv_q;
    mack_d = mack_q;
    pdat_d = pdat_q;
    wip_d = wip_q;
    set_d = set_q;
    boot_d = 1'b0;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    if (boot_q)
    begin
      for (int p = 0; p < 4; p++)
        wip_d[p] = set_q[p][0];
    end
    if (start)
    begin
      st_d = D_ADDR;
      bit_d = 4'h0;
      drv_d = 1'b0;
    end
    else if (stop)
    begin
      st_d = D_IDLE;
      drv_d = 1'b0;
      case (pend_q)
        P_ONE_DATA: set_d[pot][sel] = pdat_q;
        P_ONE_WIP: set_d[pot][sel] = wip_q[pot];
        P_ALL_WIP:
        begin
          for (int p = 0; p < 4; p++)
            set_d[p][sel] = wip_q[p];
        end
        default: ;
      endcase
      if (pend_q != P_NONE)
        cnt_d = BUSY_W'(NV_CYC);
      pend_d = P_NONE;
    end
    else
    begin
      case (st_q)
        D_ADDR, D_INSTR, D_WDATA:
        begin
          if (scl_rise && bit_q < 4'h8)
          begin
            sh_d = {sh_q[6:0], sda_lvl};
            bit_d = bit_q + 4'h1;
          end
          else if (scl_fall && bit_q == 4'h8)
          begin
            drv_d = 1'b1;
            bit_d = 4'h9;
            case (st_q)
              D_ADDR:
              begin
                nxt_d = D_INSTR;
                if (sh_q != {DEV_TYPE, ADDRESS_PINS} || cnt_q != '0)
                begin
                  drv_d = 1'b0;
                  st_d = D_SKIP;
                end
              end
              D_INSTR:
              begin
                ins_d = sh_q;
                nxt_d = D_SKIP;
                case (qw_len(sh_q))
                  LEN_WRITE: nxt_d = D_WDATA;
                  LEN_READ: nxt_d = D_RDATA;
                  LEN_STEP: nxt_d = D_STEP;
                  LEN_TWO:
                  begin
                    case (sh_q[OP_LSB +: 4])
                      OP_SET2WIP: wip_d[npot] = set_q[npot][nsel];
                      OP_WIP2SET: pend_d = P_ONE_WIP;
                      OP_GSET2WIP:
                      begin
                        for (int p = 0; p < 4; p++)
                          wip_d[p] = set_q[p][nsel];
                      end
                      OP_GWIP2SET: pend_d = P_ALL_WIP;
                      default: ;
                    endcase
                  end
                  default: ;
                endcase
              end
              default:
              begin
                if (ins_q[OP_LSB +: 4] == OP_WR_WIPER)
                  wip_d[pot] = sh_q[5:0];
                else
                begin
                  pend_d = P_ONE_DATA;
                  pdat_d = sh_q[5:0];
                end
              end
            endcase
          end
          else if (scl_fall && bit_q == 4'h9)
          begin
            drv_d = 1'b0;
            bit_d = 4'h0;
            st_d = nxt_q;
            if (nxt_q == D_RDATA)
            begin
              tx_d = rdv;
              drv_d = ~rdv[7];
            end
          end
        end
        D_RDATA:
        begin
          if (scl_rise && bit_q == 4'h8)
            mack_d = ~sda_lvl;
          else if (scl_fall)
          begin
            if (bit_q == 4'h8)
            begin
              if (mack_q)
              begin
                bit_d = 4'h0;
                tx_d = rdv;
                drv_d = ~rdv[7];
              end
              else
              begin
                st_d = D_SKIP;
                drv_d = 1'b0;
              end
            end
            else if (bit_q == 4'h7)
            begin
              bit_d = 4'h8;
              drv_d = 1'b0;
            end
            else
            begin
              bit_d = bit_q + 4'h1;
              tx_d = {tx_q[6:0], 1'b0};
              drv_d = ~tx_q[6];
            end
          end
        end
        D_STEP:
        begin
          // a pulse counts once it ends: the stop's own pulse never ends
          if (scl_fall)
          begin
            if (sda_lvl)
              wip_d[pot] = (wip_q[pot] == VAL_MAX) ? VAL_MAX :
                wip_q[pot] + 6'h01;
            else
              wip_d[pot] = (wip_q[pot] == VAL_MIN) ? VAL_MIN :
                wip_q[pot] - 6'h01;
          end
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q <= D_IDLE;
      nxt_q <= D_IDLE;
      pend_q <= P_NONE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ins_q <= 8'h00;
      drv_q <= 1'b0;
      mack_q <= 1'b0;
      boot_q <= 1'b1;
      pdat_q <= 6'h00;
      cnt_q <= '0;
      wip_q <= '0;
      set_q <= {16{SET_RST}};
    end
    else
    begin
      st_q <= st_d;
      nxt_q <= nxt_d;
      pend_q <= pend_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      ins_q <= ins_d;
      drv_q <= drv_d;
      mack_q <= mack_d;
      boot_q <= boot_d;
      pdat_q <= pdat_d;
      cnt_q <= cnt_d;
      wip_q <= wip_d;
      set_q <= set_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_tap
      assign TAP_SELECT[g] = 64'h1 << wip_q[g];
    end
  endgenerate

  assign WIPER_POSITION = wip_q;
  assign NV_BUSY = (cnt_q != '0);
  assign LNK.sda_d_o = 1'b0;
  assign LNK.sda_d_oe_n = ~drv_q;
endmodule // qw_dev

`default_nettype wire

/* File: pkg/qw_pkg.sv */
// qw_pkg: shared constants, types and decode for the quad wiper link
// assumes: both ends run on a 200 MHz core clock
`default_nettype none

package qw_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int NV_PROG_MS = 5;
  localparam int NV_PROG_CYC = NV_PROG_MS * 1000 * CLK_MHZ;
  localparam int BUSY_W = 20;
  localparam int SCL_PERIOD_NS = 200;
  localparam int SCL_QTR_CYC = SCL_PERIOD_NS * CLK_MHZ / 4000;
  localparam int QTR_W = 4;

  // ------------------------------------------------------------
  // addressing and instruction layout
  // ------------------------------------------------------------
  // device type code: value is arbitrary
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int OP_LSB = 4;
  localparam int POT_LSB = 2;
  localparam int SEL_LSB = 0;

  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'ha;
  localparam logic [3:0] OP_RD_SET = 4'hb;
  localparam logic [3:0] OP_WR_SET = 4'hc;
  localparam logic [3:0] OP_SET2WIP = 4'hd;
  localparam logic [3:0] OP_WIP2SET = 4'he;
  localparam logic [3:0] OP_GSET2WIP = 4'h1;
  localparam logic [3:0] OP_GWIP2SET = 4'h8;
  localparam logic [3:0] OP_STEP = 4'h2;

  // ------------------------------------------------------------
  // values
  // ------------------------------------------------------------
  typedef logic [5:0] qw_val_t;
  typedef qw_val_t [3:0] qw_wipers_t;
  typedef logic [3:0][63:0] qw_taps_t;
  localparam qw_val_t VAL_MAX = 6'h3f;
  localparam qw_val_t VAL_MIN = 6'h00;
  localparam qw_val_t SET_RST = 6'h20;

  // ------------------------------------------------------------
  // host apb map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_INSTR_LSB = 4;
  localparam int CMD_DATA_LSB = 12;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_RDATA_LSB = 8;

  typedef enum {LEN_TWO, LEN_WRITE, LEN_READ, LEN_STEP, LEN_BAD} qw_len_t;

  // instruction shape, with the fixed zero fields checked
  function automatic qw_len_t qw_len(input logic [7:0] ins);
    logic z_sel;
    logic z_pot;
    z_sel = (ins[1:0] == 2'h0);
    z_pot = (ins[3:2] == 2'h0);
    case (ins[7:4])
      OP_RD_WIPER: qw_len = z_sel ? LEN_READ : LEN_BAD;
      OP_WR_WIPER: qw_len = z_sel ? LEN_WRITE : LEN_BAD;
      OP_RD_SET: qw_len = LEN_READ;
      OP_WR_SET: qw_len = LEN_WRITE;
      OP_SET2WIP, OP_WIP2SET: qw_len = LEN_TWO;
      OP_GSET2WIP, OP_GWIP2SET: qw_len = z_pot ? LEN_TWO : LEN_BAD;
      OP_STEP: qw_len = z_sel ? LEN_STEP : LEN_BAD;
      default: qw_len = LEN_BAD;
    endcase
  endfunction

endpackage

`default_nettype wire

/* File: pkg/qw_if.sv */
// qw_if: two-wire link between host and device ends
// assumes: open-drain wires pulled high when nobody drives
`default_nettype none

interface qw_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic scl;
  logic sda;

  // wired-and with pull-up
  assign scl = scl_oe_n | scl_o;
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);

  modport host (output scl_o, output scl_oe_n, output sda_h_o,
    output sda_h_oe_n, input scl, input sda);
  modport dev (output sda_d_o, output sda_d_oe_n, input scl, input sda);
endinterface

`default_nettype wire

/* File: hw/qw_pin_sync.sv */
// qw_pin_sync: three-flop input filter with edge pulses
// assumes: pin is asynchronous to clk, idles high
`default_nettype none

module qw_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic lvl,
  output logic rise,
  output logic fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;

  // level changes once second and third flop agree
  always_comb
  begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign lvl = lvl_q;
  assign rise = lvl_d & ~lvl_q;
  assign fall = ~lvl_d & lvl_q;
endmodule // qw_pin_sync

`default_nettype wire

/* File: hw/qw_host.sv */
// qw_host: apb-controlled master end of the quad wiper link
// assumes: apb master on CORE_CLK, device on the shared link
`default_nettype none

module qw_host
  import qw_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  qw_if.host LNK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  import qw_pkg::*;

  typedef enum {H_IDLE, H_START, H_BIT, H_STOP} qw_hst_t;

  logic sda_lvl;
  qw_pin_sync u_sda (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .pin(LNK.sda),
    .lvl(sda_lvl),
    .rise(),
    .fall()
  );

  qw_hst_t hst_q, hst_d;
  logic [QTR_W-1:0] qc_q, qc_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] byte_q, byte_d;
  logic [7:0] sh_q, sh_d;
  logic scl_low_q, scl_low_d;
  logic sda_low_q, sda_low_d;
  logic nack_q, nack_d;
  logic [7:0] rdat_q, rdat_d;
  logic [19:0] cmd_q, cmd_d;
  logic [31:0] prd_q, prd_d;
  logic tick;
  logic acc;
  logic bad;
  logic go;
  logic rd;
  logic stp;
  logic [1:0] last;
  qw_len_t len;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign acc = PSEL & PENABLE;
  assign bad = (PADDR != REG_CMD && PADDR != REG_STAT) ||
    (PWRITE && (PADDR == REG_STAT || hst_q != H_IDLE));
  assign go = acc & PWRITE & ~bad;
  assign PREADY = 1'b1;
  assign PSLVERR = acc & bad;
  assign PRDATA = prd_q;

  assign len = qw_len(cmd_q[CMD_INSTR_LSB +: 8]);
  assign rd = (byte_q == 2'h2) && (len == LEN_READ);
  assign stp = (byte_q == 2'h2) && (len == LEN_STEP);
  assign last = (len == LEN_TWO || len == LEN_BAD) ? 2'h1 : 2'h2;
  assign tick = (qc_q == QTR_W'(SCL_QTR_CYC - 1));

  // ------------------------------------------------------------
  // bus sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    hst_d = hst_q;
    ph_d = ph_q;
    bit_d = bit_q;
    byte_d = byte_q;
    sh_d = sh_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    nack_d = nack_q;
    rdat_d = rdat_q;
    cmd_d = cmd_q;
    qc_d = (hst_q == H_IDLE || tick) ? '0 : qc_q + 1'b1;
    prd_d = prd_q;
    if (PSEL && !PENABLE)
    begin
      prd_d = 32'h0;
      if (PADDR == REG_STAT)
      begin
        prd_d[STAT_BUSY] = (hst_q != H_IDLE);
        prd_d[STAT_NACK] = nack_q;
        prd_d[STAT_RDATA_LSB +: 8] = rdat_q;
      end
      else if (PADDR == REG_CMD)
        prd_d[19:0] = cmd_q;
    end
    case (hst_q)
      H_IDLE:
      begin
        if (go)
        begin
          cmd_d = PWDATA[19:0];
          hst_d = H_START;
          ph_d = 2'h0;
          nack_d = 1'b0;
        end
      end
      H_START:
      begin
        if (tick)
        begin
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h0)
            sda_low_d = 1'b1;
          else
          begin
            scl_low_d = 1'b1;
            hst_d = H_BIT;
            ph_d = 2'h0;
            bit_d = 4'h0;
            byte_d = 2'h0;
            sh_d = {DEV_TYPE, cmd_q[CMD_ADDR_LSB +: 4]};
          end
        end
      end
      H_BIT:
      begin
        if (tick)
        begin
          ph_d = ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_low_d = (bit_q < 4'h8 && !rd) ? ~sh_q[7] : 1'b0;
            2'h2: scl_low_d = 1'b0;
            2'h3:
            begin
              scl_low_d = 1'b1;
              if (bit_q < 4'h8)
              begin
                sh_d = {sh_q[6:0], rd ? sda_lvl : 1'b0};
                bit_d = bit_q + 4'h1;
                if (stp && bit_q == 4'h7)
                  hst_d = H_STOP;
              end
              else
              begin
                bit_d = 4'h0;
                if (rd)
                begin
                  rdat_d = sh_q;
                  hst_d = H_STOP;
                end
                else if (sda_lvl)
                begin
                  nack_d = 1'b1;
                  hst_d = H_STOP;
                end
                else if (byte_q == last)
                  hst_d = H_STOP;
                else
                begin
                  byte_d = byte_q + 2'h1;
                  sh_d = (byte_q == 2'h0) ? cmd_q[CMD_INSTR_LSB +: 8] :
                    cmd_q[CMD_DATA_LSB +: 8];
                end
              end
            end
            default: ;
          endcase
        end
      end
      H_STOP:
      begin
        if (tick)
        begin
          ph_d = ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_low_d = 1'b1;
            2'h2: scl_low_d = 1'b0;
            2'h3:
            begin
              sda_low_d = 1'b0;
              hst_d = H_IDLE;
            end
            default: ;
          endcase
        end
      end
      default: hst_d = H_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      hst_q <= H_IDLE;
      qc_q <= '0;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      nack_q <= 1'b0;
      rdat_q <= 8'h00;
      cmd_q <= 20'h0;
      prd_q <= 32'h0;
    end
    else
    begin
      hst_q <= hst_d;
      qc_q <= qc_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      sh_q <= sh_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      nack_q <= nack_d;
      rdat_q <= rdat_d;
      cmd_q <= cmd_d;
      prd_q <= prd_d;
    end
  end

  assign LNK.scl_o = 1'b0;
  assign LNK.scl_oe_n = ~scl_low_q;
  assign LNK.sda_h_o = 1'b0;
  assign LNK.sda_h_oe_n = ~sda_low_q;
endmodule // qw_host

`default_nettype wire

/* File: tb/qw_link_checker.sv */
// qw_link_checker: concurrent checks on the link wires and device outputs
// assumes: instantiated in tb beside the link interface
`default_nettype none

module qw_link_checker
  import qw_pkg::*;
#(
  parameter int NV_CYC = 2000
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_oe_n,
  input wire qw_pkg::qw_wipers_t WIPER_POSITION,
  input wire qw_pkg::qw_taps_t TAP_SELECT,
  input wire logic NV_BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  qw_taps_t tap_exp;

  // --------------------------------------------------------
  // busy length counter and tap decode
  // --------------------------------------------------------
  always_comb
  begin
    cnt_d = NV_BUSY ? cnt_q + 32'h1 : 32'h0;
    for (int i = 0; i < 4; i++)
    begin
      tap_exp[i] = 64'h1 << WIPER_POSITION[i];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_d;
  end

  // --------------------------------------------------------
  // properties
  // --------------------------------------------------------
  a_wiper_load: assert property (
    $rose(RST_N) |-> ##2 WIPER_POSITION == {4{SET_RST}})
    else $error("wipers not loaded from setting zero");
  a_dev_sda_chg: assert property (
    $changed(sda_d_oe_n) |-> !scl)
    else $error("device sda changed with scl high");
  a_ack_hold: assert property (
    $fell(sda_d_oe_n) |-> !sda_d_oe_n [*8])
    else $error("device drive too short");
  a_busy_quiet: assert property (NV_BUSY |-> sda_d_oe_n)
    else $error("device drives sda while programming");
  a_busy_hold: assert property (
    NV_BUSY && $past(NV_BUSY) |-> $stable(WIPER_POSITION))
    else $error("wiper moved while programming");
  a_busy_at_stop: assert property ($rose(NV_BUSY) |-> scl && sda)
    else $error("programming not started at stop");
  a_busy_len: assert property (
    $fell(NV_BUSY) |-> cnt_q >= NV_CYC - 1 && cnt_q <= NV_CYC + 1)
    else $error("programming time wrong");
  a_tap_onehot: assert property (TAP_SELECT == tap_exp)
    else $error("tap decode not one-hot of wiper");

  c_busy: cover property ($rose(NV_BUSY));
  c_ack: cover property ($fell(sda_d_oe_n));
  c_wiper: cover property ($changed(WIPER_POSITION));
endmodule // qw_link_checker

`default_nettype wire

/* File: tb/tb.sv */
// tb: host and device ends joined on one link, commands issued over apb
// assumes: link pulled high in the interface, NV_CYC shortened
`default_nettype none

`define CHK(nm, e, s) \
  begin num_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import qw_pkg::*;

  typedef struct packed {
    logic [7:0] ins;
    logic [7:0] dat;
    logic rd;
    logic [1:0] pot;
    qw_val_t ev;
    logic nv;
    logic bad;
  } qw_row_t;

  localparam int NV = 2000;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, nv_busy, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, st, rd;
  logic [3:0] pins;
  qw_wipers_t wip;
  qw_taps_t taps;
  int num_errors = 0;
  int num_checks = 0;
  qw_if lnk ();

  qw_host i_qw_host (.CORE_CLK(clk), .RST_N(rst_n), .LNK(lnk), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  qw_dev #(.NV_CYC(NV)) i_qw_dev (.CORE_CLK(clk), .RST_N(rst_n), .LNK(lnk),
    .ADDRESS_PINS(pins), .WIPER_POSITION(wip), .TAP_SELECT(taps),
    .NV_BUSY(nv_busy));
  qw_link_checker #(.NV_CYC(NV)) i_qw_link_checker (.CORE_CLK(clk),
    .RST_N(rst_n), .scl(lnk.scl), .sda(lnk.sda),
    .sda_d_oe_n(lnk.sda_d_oe_n), .WIPER_POSITION(wip), .TAP_SELECT(taps),
    .NV_BUSY(nv_busy));

  // --------------------------------------------------------
  // command rows: ins, data, read, pot, expected, programs, refused
  // --------------------------------------------------------
  qw_row_t rows [17] = '{
    '{8'ha4, 8'hff, 1'h0, 2'h1, 6'h3f, 1'h0, 1'h0},
    '{8'h94, 8'h00, 1'h1, 2'h1, 6'h3f, 1'h0, 1'h0},
    '{8'hcb, 8'h15, 1'h0, 2'h2, 6'h20, 1'h1, 1'h0},
    '{8'hbb, 8'h00, 1'h1, 2'h0, 6'h15, 1'h0, 1'h0},
    '{8'hdb, 8'h00, 1'h0, 2'h2, 6'h15, 1'h0, 1'h0},
    '{8'he6, 8'h00, 1'h0, 2'h1, 6'h3f, 1'h1, 1'h0},
    '{8'hb6, 8'h00, 1'h1, 2'h0, 6'h3f, 1'h0, 1'h0},
    '{8'h81, 8'h00, 1'h0, 2'h0, 6'h20, 1'h1, 1'h0},
    '{8'hb9, 8'h00, 1'h1, 2'h0, 6'h15, 1'h0, 1'h0},
    '{8'ha0, 8'h01, 1'h0, 2'h0, 6'h01, 1'h0, 1'h0},
    '{8'h11, 8'h00, 1'h0, 2'h0, 6'h20, 1'h0, 1'h0},
    '{8'h34, 8'h00, 1'h0, 2'h0, 6'h20, 1'h0, 1'h1},
    '{8'hac, 8'h3e, 1'h0, 2'h3, 6'h3e, 1'h0, 1'h0},
    '{8'h2c, 8'hff, 1'h0, 2'h3, 6'h3f, 1'h0, 1'h0},
    '{8'hac, 8'h01, 1'h0, 2'h3, 6'h01, 1'h0, 1'h0},
    '{8'h2c, 8'h0f, 1'h0, 2'h3, 6'h04, 1'h0, 1'h0},
    '{8'ha5, 8'h33, 1'h0, 2'h1, 6'h3f, 1'h0, 1'h1}};

  task automatic end_of_test();
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    end_of_test();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] d, output logic e);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    d = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
    if (n >= 50)
      hang();
  endtask

  task automatic cmd(input logic [7:0] ins, input logic [7:0] dat);
    logic [31:0] d;
    logic e;
    int n;
    apb(1'h1, REG_CMD, {12'h0, dat, ins, 4'h5}, d, e);
    n = 0;
    do
    begin
      apb(1'h0, REG_STAT, 32'h0, st, e);
      n++;
    end
    while ((n < 2 || st[STAT_BUSY] !== 1'h0) && n < 1000);
    if (n >= 1000)
      hang();
  endtask

  task automatic nv_wait(input logic lvl);
    int n;
    for (n = 0; nv_busy !== lvl && n < 3000; n++)
      @(posedge clk);
    if (n >= 3000)
      hang();
  endtask

  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pins = 4'h5;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    `CHK("wiper", {4{SET_RST}}, wip)
    foreach (rows[i])
    begin
      cmd(rows[i].ins, rows[i].dat);
      if (rows[i].nv)
      begin
        nv_wait(1'h1);
        nv_wait(1'h0);
      end
      if (!rows[i].bad)
        `CHK("nack", 1'h0, st[STAT_NACK])
      if (rows[i].rd)
        `CHK("rdata", {2'h0, rows[i].ev}, st[15:8])
      else
        `CHK("wiper", rows[i].ev, wip[rows[i].pot])
    end
    cmd(8'hc0, 8'h0a);
    nv_wait(1'h1);
    cmd(8'h90, 8'h00);
    `CHK("busy nack", 1'h1, st[STAT_NACK])
    nv_wait(1'h0);
    cmd(8'hb0, 8'h00);
    `CHK("setting", 8'h0a, st[15:8])
    pins <= 4'h6;
    cmd(8'ha0, 8'h11);
    `CHK("adr nack", 1'h1, st[STAT_NACK])
    `CHK("wiper0", 6'h20, wip[0])
    pins <= 4'h5;
    apb(1'h1, 8'h08, 32'h1, rd, er);
    `CHK("pslverr", 1'h1, er)
    apb(1'h0, 8'h08, 32'h0, rd, er);
    `CHK("unmapped", 32'h0, rd)
    rst_n <= 1'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    `CHK("wiper rst", {4{SET_RST}}, wip)
    end_of_test();
  end
endmodule // tb

`default_nettype wire
